// *** verilog/input_port_pkg.sv ***
// package: register map, field layout and reset values of the input port block
`default_nettype none
package input_port_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 4;
  localparam int unsigned GROUP_W = 4;
  localparam logic [7:0] OFS_LOW_SELECT   = 8'hC0;
  localparam logic [7:0] OFS_LOW_LEVEL    = 8'hC1;
  localparam logic [7:0] OFS_HIGH_SELECT  = 8'hC2;
  localparam logic [7:0] OFS_HIGH_LEVEL   = 8'hC3;
  localparam logic [7:0] OFS_MASK_BANK    = 8'hF0;
  localparam logic [7:0] OFS_HIGH_FLAG    = 8'hF2;
  localparam logic [7:0] OFS_LOW_FLAG     = 8'hF3;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'hE0;
  localparam logic [7:0] OFS_IRQ_ENABLE   = 8'hE1;
  localparam int unsigned POS_LOW_MASK  = 2;
  localparam int unsigned POS_HIGH_MASK = 3;
  localparam int unsigned POS_FLAG      = 0;
  localparam logic [3:0] RST_SELECT = 4'h0;
  localparam logic [3:0] RST_MASK   = 4'h0;
  localparam logic [1:0] RST_FLAG   = 2'h0;
  localparam logic [1:0] RST_STATUS = 2'h0;
  localparam logic [1:0] RST_ENABLE = 2'h0;
  localparam logic [3:0] RST_RDATA  = 4'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
endpackage
`default_nettype wire

// *** verilog/input_port_interrupt_unit.sv ***
// eight-pin input port with per-pin edge select, group flags and masks
//
// What this block does
// - pin-data reads return pin levels from the second sync flop
// - pin-data registers ignore writes
// - per-pin select bits, writable, reset zero
// - unselected pins never raise events
// - group mask bits 2 and 3, reset zero
// - group flags in bit 0, writes ignored
// - reading a flag clears it
// - flags are zero after reset
// - upper flag register bits read zero
// - events are rising edges of pins
// - low and high groups are separate sources
// - selected pin event sets group flag
// - any selected event pulses wake-up
`timescale 1ns/100ps
`default_nettype none
module input_port_interrupt_unit
  import input_port_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              clk_en_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic [GROUP_W-1:0] low_group_pins_i,
  input  wire logic [GROUP_W-1:0] high_group_pins_i,
  output logic                   low_group_irq_o,
  output logic                   high_group_irq_o,
  output logic                   wakeup_o,
  output logic                   irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  reg_req_t req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  logic [2*GROUP_W-1:0] pins_meta_reg;
  logic [2*GROUP_W-1:0] pins_sync_reg;
  logic [2*GROUP_W-1:0] pins_prev_reg;
  logic [GROUP_W-1:0]   low_pin_irq_select_reg;
  logic [GROUP_W-1:0]   high_pin_irq_select_reg;
  logic [3:0]           mask_bank_reg;
  logic [1:0]           flag_reg;
  logic [1:0]           flag_next;
  logic [1:0]           status_reg;
  logic [1:0]           status_next;
  logic [1:0]           irq_enable_reg;
  logic [DATA_W-1:0]    rdata_reg;
  logic                 wakeup_reg;

  wire [2*GROUP_W-1:0] select_all = {high_pin_irq_select_reg, low_pin_irq_select_reg};
  wire [2*GROUP_W-1:0] rise;

  // a pin counts only on a rising edge while selected; prev reads the second
  // sync flop only, so a metastable first stage never reaches the detector
  genvar pin;
  for (pin = 0; pin < 2*GROUP_W; pin++) begin : g_pin
    assign rise[pin] = pins_sync_reg[pin] & ~pins_prev_reg[pin] & select_all[pin];
  end
  wire [1:0] group_event = {|rise[2*GROUP_W-1:GROUP_W], |rise[GROUP_W-1:0]};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
      pins_prev_reg <= '0;
    end else if (clk_en_i) begin
      pins_meta_reg <= {high_group_pins_i, low_group_pins_i};
      pins_sync_reg <= pins_meta_reg;
      pins_prev_reg <= pins_sync_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register decode

  wire sel_low_select  = req.addr == OFS_LOW_SELECT;
  wire sel_low_level   = req.addr == OFS_LOW_LEVEL;
  wire sel_high_select = req.addr == OFS_HIGH_SELECT;
  wire sel_high_level  = req.addr == OFS_HIGH_LEVEL;
  wire sel_mask        = req.addr == OFS_MASK_BANK;
  wire sel_high_flag   = req.addr == OFS_HIGH_FLAG;
  wire sel_low_flag    = req.addr == OFS_LOW_FLAG;
  wire sel_status      = req.addr == OFS_IRQ_STATUS;
  wire sel_enable      = req.addr == OFS_IRQ_ENABLE;

  wire [1:0] flag_read_clr = {req.rd & sel_high_flag, req.rd & sel_low_flag};
  wire [1:0] status_w1c = (req.wr & sel_status) ? req.wdata[1:0] : 2'h0;
  wire wr_low_select  = req.wr & sel_low_select;
  wire wr_high_select = req.wr & sel_high_select;
  wire wr_mask        = req.wr & sel_mask;
  wire wr_enable      = req.wr & sel_enable;

  // set wins over read-clear so an edge in the read cycle is not lost
  assign flag_next   = (flag_reg & ~flag_read_clr) | group_event;
  assign status_next = (status_reg & ~status_w1c) | group_event;

  wire [DATA_W-1:0] rdata_mux =
      sel_low_select  ? low_pin_irq_select_reg :
      sel_low_level   ? pins_sync_reg[GROUP_W-1:0] :
      sel_high_select ? high_pin_irq_select_reg :
      sel_high_level  ? pins_sync_reg[2*GROUP_W-1:GROUP_W] :
      sel_mask        ? mask_bank_reg :
      sel_high_flag   ? {3'h0, flag_reg[1]} :
      sel_low_flag    ? {3'h0, flag_reg[0]} :
      sel_status      ? {2'h0, status_reg} :
      sel_enable      ? {2'h0, irq_enable_reg} :
      4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // registers; level and flag addresses have no write path

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      low_pin_irq_select_reg  <= RST_SELECT;
      high_pin_irq_select_reg <= RST_SELECT;
    end else if (clk_en_i) begin
      if (wr_low_select) begin
        low_pin_irq_select_reg <= req.wdata;
      end
      if (wr_high_select) begin
        high_pin_irq_select_reg <= req.wdata;
      end
    end
  end

  // no lock against writes with interrupts on; software keeps that rule
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mask_bank_reg <= RST_MASK;
    end else if (clk_en_i && wr_mask) begin
      mask_bank_reg <= req.wdata;
    end
  end

  // flags take no write data, so a write to them changes nothing
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flag_reg   <= RST_FLAG;
      status_reg <= RST_STATUS;
    end else if (clk_en_i) begin
      flag_reg   <= flag_next;
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_enable_reg <= RST_ENABLE;
    end else if (clk_en_i && wr_enable) begin
      irq_enable_reg <= req.wdata[1:0];
    end
  end

  // read data stand for one cycle only, then fall back to zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg  <= RST_RDATA;
      wakeup_reg <= 1'b0;
    end else if (clk_en_i) begin
      rdata_reg  <= req.rd ? rdata_mux : RST_RDATA;
      wakeup_reg <= |group_event;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata_o          = rdata_reg;
  assign low_group_irq_o  = flag_reg[0] & mask_bank_reg[POS_LOW_MASK];
  assign high_group_irq_o = flag_reg[1] & mask_bank_reg[POS_HIGH_MASK];
  assign wakeup_o         = wakeup_reg;
  assign irq_o            = |(status_reg & irq_enable_reg);

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_low_rise;
    clk_en_i && rise[0] && !flag_reg[0];
  endsequence

  property p_flag_set;
    @(posedge clk_i) disable iff (reset_i) s_low_rise |=> flag_reg[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("low flag not set");

  property p_read_clear;
    @(posedge clk_i) disable iff (reset_i)
      clk_en_i && rd_i && sel_low_flag && !group_event[0] |=> !flag_reg[0];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared");

  property p_unselected;
    @(posedge clk_i) disable iff (reset_i)
      clk_en_i && low_pin_irq_select_reg == 4'h0 && !flag_reg[0] && !rd_i
      |=> !flag_reg[0];
  endproperty
  a_unselected: assert property (p_unselected) else $error("unselected pin set flag");

  // opening the mask over a pending flag raises the request at once
  sequence s_high_mask_on;
    clk_en_i && wr_i && sel_mask && wdata_i[POS_HIGH_MASK] && flag_reg[1];
  endsequence

  property p_req;
    @(posedge clk_i) disable iff (reset_i) s_high_mask_on |=> high_group_irq_o;
  endproperty
  a_req: assert property (p_req) else $error("high request wrong");

  property p_upper_zero;
    @(posedge clk_i) disable iff (reset_i)
      clk_en_i && rd_i && (sel_low_flag || sel_high_flag) |=> rdata_o[3:1] == 3'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("flag upper bits set");

  property p_level_read;
    @(posedge clk_i) disable iff (reset_i)
      clk_en_i && rd_i && sel_high_level |=> rdata_o == $past(pins_sync_reg[7:4]);
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read wrong");

  property p_level_ro;
    @(posedge clk_i) disable iff (reset_i)
      clk_en_i && wr_i && sel_low_level |=> $stable(mask_bank_reg)
        && $stable(low_pin_irq_select_reg) && $stable(high_pin_irq_select_reg);
  endproperty
  a_level_ro: assert property (p_level_ro) else $error("level write had effect");

  property p_wake;
    @(posedge clk_i) disable iff (reset_i) clk_en_i && |rise |=> wakeup_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake-up");

  property p_mask_write;
    @(posedge clk_i) disable iff (reset_i)
      clk_en_i && wr_i && sel_mask |=> mask_bank_reg == $past(wdata_i);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  sequence s_low_event_open;
    clk_en_i && group_event[0] && mask_bank_reg[POS_LOW_MASK] && !(wr_i && sel_mask);
  endsequence

  property p_low_req;
    @(posedge clk_i) disable iff (reset_i) s_low_event_open |=> low_group_irq_o;
  endproperty
  a_low_req: assert property (p_low_req) else $error("low request missing");

  property p_select_write;
    @(posedge clk_i) disable iff (reset_i)
      clk_en_i && wr_i && sel_high_select |=> high_pin_irq_select_reg == $past(wdata_i);
  endproperty
  a_select_write: assert property (p_select_write) else $error("select not written");

  property p_flag_write;
    @(posedge clk_i) disable iff (reset_i)
      clk_en_i && wr_i && !rd_i && sel_low_flag && flag_reg[0] |=> flag_reg[0];
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag write had effect");

  property p_reset_flags;
    @(posedge clk_i) reset_i |=> flag_reg == RST_FLAG
      && !low_group_irq_o && !high_group_irq_o;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flag set after reset");

  property p_group_apart;
    @(posedge clk_i) disable iff (reset_i)
      clk_en_i && group_event[0] && !group_event[1] && !flag_reg[1] |=> !flag_reg[1];
  endproperty
  a_group_apart: assert property (p_group_apart) else $error("low event set high flag");

  sequence s_high_rise;
    clk_en_i && |rise[2*GROUP_W-1:GROUP_W];
  endsequence

  property p_high_flag_set;
    @(posedge clk_i) disable iff (reset_i) s_high_rise |=> flag_reg[1];
  endproperty
  a_high_flag_set: assert property (p_high_flag_set) else $error("high flag not set");

  property p_freeze;
    @(posedge clk_i) disable iff (reset_i)
      !clk_en_i |=> $stable(flag_reg) && $stable(mask_bank_reg) && $stable(rdata_o)
        && $stable(low_pin_irq_select_reg) && $stable(high_pin_irq_select_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_irq_line;
    @(posedge clk_i) disable iff (reset_i)
      clk_en_i && group_event[1] && irq_enable_reg[1] && !(wr_i && sel_enable) |=> irq_o;
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("interrupt line not raised");

endmodule
`default_nettype wire

// *** dv/key_pad_model.sv ***
// external switch model driving both input pin groups
`timescale 1ns/100ps
`default_nettype none
module key_pad_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] press_i,
  output logic      [3:0] low_group_pins_o,
  output logic      [3:0] high_group_pins_o
);
  // levels move just after an edge, so the sync flops never see a race
  always @(posedge clk_i) begin
    low_group_pins_o  <= press_i[3:0];
    high_group_pins_o <= press_i[7:4];
  end
endmodule
`default_nettype wire

// *** dv/input_port_interrupt_unit_tb.sv ***
// bench: register access, pin events and interrupt outputs
`timescale 1ns/100ps
`default_nettype none
module input_port_interrupt_unit_tb;
  import input_port_pkg::*;
  logic              clk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = 8'h00;
  logic [DATA_W-1:0] wdata_i = 4'h0;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic              clk_en = 1'b1;
  logic [7:0]        press = 8'hA5;
  logic [3:0]        rdata_o, low_pins, high_pins;
  logic              low_irq, high_irq, wakeup_o, irq_o;
  int                mismatches = 0;
  int                checked = 0;
  always #5 clk_i = ~clk_i;
  key_pad_model pads (.clk_i(clk_i), .press_i(press), .low_group_pins_o(low_pins),
    .high_group_pins_o(high_pins));
  input_port_interrupt_unit dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .low_group_pins_i(low_pins), .high_group_pins_i(high_pins),
    .low_group_irq_o(low_irq), .high_group_irq_o(high_irq), .wakeup_o(wakeup_o),
    .irq_o(irq_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [3:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge clk_i);
    press <= v;
    repeat (6) @(posedge clk_i);
  endtask
  // the wake pulse lasts one cycle, so it is sampled after every edge
  task automatic rise_wake(input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    press <= v;
    while (wakeup_o !== 1'b1 && n < 12) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({3'h0, wakeup_o}, 4'h1);
    if (wakeup_o !== 1'b1) end_sim();
    @(posedge clk_i);
    #1;
    chk({3'h0, wakeup_o}, 4'h0);
    @(posedge clk_i);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(OFS_LOW_SELECT, 4'h0);
    rd(OFS_HIGH_SELECT, 4'h0);
    rd(OFS_MASK_BANK, 4'h0);
    rd(OFS_LOW_FLAG, 4'h0);
    rd(OFS_HIGH_FLAG, 4'h0);
    $display("test reset done");
    wr(OFS_LOW_LEVEL, 4'h0);
    rd(OFS_LOW_LEVEL, 4'h5);
    rd(OFS_HIGH_LEVEL, 4'hA);
    $display("test levels done");
    wr(OFS_LOW_SELECT, 4'hF);
    rd(OFS_LOW_SELECT, 4'hF);
    wr(OFS_MASK_BANK, 4'h4);
    rd(OFS_MASK_BANK, 4'h4);
    pins(8'h00);
    pins(8'hF0);
    rd(OFS_HIGH_FLAG, 4'h0);
    rd(OFS_LOW_FLAG, 4'h0);
    $display("test no event done");
    rise_wake(8'hF8);
    chk({2'h0, high_irq, low_irq}, 4'h1);
    wr(OFS_LOW_FLAG, 4'h0);
    rd(OFS_LOW_FLAG, 4'h1);
    rd(OFS_LOW_FLAG, 4'h0);
    $display("test low event done");
    wr(OFS_MASK_BANK, 4'h0);
    wr(OFS_HIGH_SELECT, 4'h1);
    wr(OFS_IRQ_ENABLE, 4'h3);
    wr(OFS_IRQ_STATUS, 4'h3);
    pins(8'h08);
    rise_wake(8'h18);
    chk({2'h0, high_irq, low_irq}, 4'h0);
    chk({3'h0, irq_o}, 4'h1);
    rd(OFS_IRQ_STATUS, 4'h2);
    rd(OFS_IRQ_ENABLE, 4'h3);
    wr(OFS_MASK_BANK, 4'h8);
    #1;
    chk({2'h0, high_irq, low_irq}, 4'h2);
    rd(OFS_HIGH_FLAG, 4'h1);
    chk({2'h0, high_irq, low_irq}, 4'h0);
    rd(OFS_LOW_FLAG, 4'h0);
    wr(OFS_IRQ_STATUS, 4'h2);
    @(posedge clk_i);
    #1;
    chk({3'h0, irq_o}, 4'h0);
    $display("test high event done");
    @(posedge clk_i);
    clk_en <= 1'b0;
    wr(OFS_LOW_SELECT, 4'h0);
    clk_en <= 1'b1;
    rd(OFS_LOW_SELECT, 4'hF);
    $display("test clock enable done");
    pins(8'h10);
    rise_wake(8'h11);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(OFS_LOW_FLAG, 4'h0);
    rd(OFS_LOW_SELECT, 4'h0);
    rd(OFS_MASK_BANK, 4'h0);
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
